// ---- core/lsi_pkg.sv ----
// Package for the LED status indicator controller.
// Assumes a single 250 MHz clock and an AHB-Lite register bus with 32-bit data.
package lsi_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHAN   = 5;
  localparam int NUM_ELEM   = 2 + 2 * NUM_CHAN;   // Colour elements in total
  localparam int RUN_W      = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int MS_NS        = 1000000;            // One millisecond in ns
  localparam int CLK_NS       = 1000 / CLK_MHZ;     // Clock period in ns
  localparam int MS_CYCLES    = MS_NS / CLK_NS;     // Cycles per millisecond tick
  localparam int SLOW_HALF_MS = 500;                // Slow blink half period
  localparam int FAST_HALF_MS = 100;                // Fast blink half period
  localparam int FLASH_MS     = 30;                 // Flash pulse width
  localparam int RUN_STEP_MS  = 200;                // Running sequence step

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_OVR_EN  = 8'h08;
  localparam logic [7:0] OFS_OVR_VAL = 8'h0C;

  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_WAVE_BIT    = 1;
  localparam int STAT_LED_LSB     = 0;
  localparam int STAT_MODE_LSB    = 12;
  localparam int STAT_OVRUN_LSB   = 16;

  localparam logic        CTRL_RST    = 1'b0;
  localparam logic [11:0] OVR_EN_RST  = 12'h000;
  localparam logic [11:0] OVR_VAL_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LSI_WAIT_CFG,
    LSI_NORMAL,
    LSI_UPDATE,
    LSI_CFG_ERR,
    LSI_PWR_FAULT,
    LSI_RUNNING,
    LSI_IDENTIFY
  } lsi_mode_e;

  typedef struct packed {
    logic [NUM_CHAN-1:0] trf_red;
    logic [NUM_CHAN-1:0] trf_yellow;
    logic                pwr_yellow;
    logic                pwr_green;
  } lsi_leds_s;

  typedef struct packed {
    logic usb_cfg_done;
    logic fw_update;
    logic fw_cfg_err;
    logic low_power;
  } lsi_dev_s;

  typedef struct packed {
    logic [NUM_CHAN-1:0] msg;
    logic [NUM_CHAN-1:0] err_frame;
    logic [NUM_CHAN-1:0] err_passive;
    logic [NUM_CHAN-1:0] overrun;
    logic [NUM_CHAN-1:0] bus_off;
  } lsi_chan_s;

endpackage : lsi_pkg

// ---- core/lsi_top.sv ----
// LED status indicator controller: patterns, channel latches, AHB-Lite registers.
// Assumes device and channel inputs come from logic on hclk; msg and
// err_frame are one-cycle pulses, the rest are levels.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module lsi_top
  import lsi_pkg::*;
#(
  parameter int MS_CYCLES_P    = MS_CYCLES,
  parameter int SLOW_HALF_MS_P = SLOW_HALF_MS,
  parameter int FAST_HALF_MS_P = FAST_HALF_MS,
  parameter int FLASH_MS_P     = FLASH_MS,
  parameter int RUN_STEP_MS_P  = RUN_STEP_MS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire lsi_dev_s    dev,
  input  wire lsi_chan_s   chan,
  output lsi_leds_s        leds
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [17:0]         ms_cnt_q;
  logic                ms_tick;
  logic [11:0]         slow_cnt_q;
  logic [11:0]         fast_cnt_q;
  logic [11:0]         run_cnt_q;
  logic                slow_ph_q;
  logic                fast_ph_q;
  logic [RUN_W-1:0]    run_idx_q;
  logic [11:0]         yel_cnt_q [NUM_CHAN];
  logic [11:0]         red_cnt_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] ovrun_q;
  lsi_mode_e           mode_q;
  lsi_mode_e           mode_d;
  lsi_leds_s           leds_d;
  logic                run_en_q;
  logic                wav_en_q;
  logic [11:0]         ovr_en_q;
  logic [11:0]         ovr_val_q;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic                addr_ph;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Millisecond enable pulse from the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= '0;
    end else if (ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 18'h0_0001;
    end
  end
  assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES_P - 1));

  // Slow and fast phase toggles with equal halves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_q <= '0;
      slow_ph_q  <= 1'b0;
      fast_cnt_q <= '0;
      fast_ph_q  <= 1'b0;
    end else if (ms_tick) begin
      if (slow_cnt_q == 12'(SLOW_HALF_MS_P - 1)) begin
        slow_cnt_q <= '0;
        slow_ph_q  <= ~slow_ph_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 12'h001;
      end
      if (fast_cnt_q == 12'(FAST_HALF_MS_P - 1)) begin
        fast_cnt_q <= '0;
        fast_ph_q  <= ~fast_ph_q;
      end else begin
        fast_cnt_q <= fast_cnt_q + 12'h001;
      end
    end
  end

  // Running sequence step position, restarts when not running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt_q <= '0;
      run_idx_q <= '0;
    end else if (mode_q != LSI_RUNNING) begin
      run_cnt_q <= '0;
      run_idx_q <= '0;
    end else if (ms_tick) begin
      if (run_cnt_q == 12'(RUN_STEP_MS_P - 1)) begin
        run_cnt_q <= '0;
        run_idx_q <= (run_idx_q == RUN_W'(NUM_ELEM - 1)) ? '0 : run_idx_q + 4'h1;
      end else begin
        run_cnt_q <= run_cnt_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel flashes and overrun latch
  // ----------------------------------------------------------------
  // Each event reloads its flash timer, so a stream of events stays lit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        yel_cnt_q[i] <= '0;
        red_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan.msg[i]) begin
          yel_cnt_q[i] <= 12'(FLASH_MS_P);
        end else if (ms_tick && yel_cnt_q[i] != '0) begin
          yel_cnt_q[i] <= yel_cnt_q[i] - 12'h001;
        end
        if (chan.err_frame[i]) begin
          red_cnt_q[i] <= 12'(FLASH_MS_P);
        end else if (ms_tick && red_cnt_q[i] != '0) begin
          red_cnt_q[i] <= red_cnt_q[i] - 12'h001;
        end
      end
    end
  end

  // Overrun holds until bus off; a new overrun wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovrun_q <= '0;
    end else begin
      ovrun_q <= chan.overrun | (ovrun_q & ~chan.bus_off);
    end
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  // Device-wide conditions first, channel traffic only in normal mode
  always_comb begin
    if (run_en_q) begin
      mode_d = LSI_RUNNING;
    end else if (dev.fw_cfg_err) begin
      mode_d = LSI_CFG_ERR;
    end else if (dev.low_power) begin
      mode_d = LSI_PWR_FAULT;
    end else if (dev.fw_update) begin
      mode_d = LSI_UPDATE;
    end else if (wav_en_q) begin
      mode_d = LSI_IDENTIFY;
    end else if (!dev.usb_cfg_done) begin
      mode_d = LSI_WAIT_CFG;
    end else begin
      mode_d = LSI_NORMAL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= LSI_WAIT_CFG;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Pattern generation
  // ----------------------------------------------------------------
  // Built-in pattern for all twelve colour elements
  always_comb begin
    leds_d = '0;
    case (mode_q)
      LSI_WAIT_CFG: begin
        leds_d.pwr_yellow = slow_ph_q;
      end
      LSI_NORMAL: begin
        leds_d.pwr_green = 1'b1;
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (ovrun_q[i]) begin
            leds_d.trf_red[i] = 1'b1;
          end else if (chan.err_passive[i]) begin
            leds_d.trf_red[i] = fast_ph_q;
          end else if (red_cnt_q[i] != '0) begin
            leds_d.trf_red[i] = 1'b1;
          end else if (yel_cnt_q[i] != '0) begin
            leds_d.trf_yellow[i] = 1'b1;
          end
        end
      end
      LSI_UPDATE: begin
        leds_d.pwr_green  = 1'b1;
        leds_d.trf_yellow = {NUM_CHAN{fast_ph_q}};
      end
      LSI_CFG_ERR: begin
        leds_d.pwr_green  = slow_ph_q;
        leds_d.pwr_yellow = ~slow_ph_q;
        leds_d.trf_yellow = {NUM_CHAN{slow_ph_q}};
        leds_d.trf_red    = {NUM_CHAN{~slow_ph_q}};
      end
      LSI_PWR_FAULT: begin
        leds_d.pwr_green  = slow_ph_q;
        leds_d.pwr_yellow = ~slow_ph_q;
        leds_d.trf_yellow = {NUM_CHAN{slow_ph_q}};
      end
      LSI_IDENTIFY: begin
        leds_d.pwr_green  = fast_ph_q;
        leds_d.pwr_yellow = ~fast_ph_q;
        leds_d.trf_yellow = {NUM_CHAN{fast_ph_q}};
        leds_d.trf_red    = {NUM_CHAN{~fast_ph_q}};
      end
      LSI_RUNNING: begin
        if (run_idx_q == 4'h0) begin
          leds_d.pwr_green = 1'b1;
        end else if (run_idx_q == 4'h1) begin
          leds_d.pwr_yellow = 1'b1;
        end else if (!run_idx_q[0]) begin
          leds_d.trf_yellow[run_idx_q[RUN_W-1:1] - 3'h1] = 1'b1;  // Channel yellow before its red
        end else begin
          leds_d.trf_red[run_idx_q[RUN_W-1:1] - 3'h1] = 1'b1;
        end
      end
      default: begin
        leds_d = '0;
      end
    endcase
  end

  // Registered outputs with per-element override
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leds <= '0;
    end else begin
      leds <= lsi_leds_s'((ovr_val_q & ovr_en_q) | (12'(leds_d) & ~ovr_en_q));
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ph   = hsel && hready && htrans[1];

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_en_q  <= CTRL_RST;
      wav_en_q  <= CTRL_RST;
      ovr_en_q  <= OVR_EN_RST;
      ovr_val_q <= OVR_VAL_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == OFS_CTRL) begin
        run_en_q <= hwdata[CTRL_RUN_BIT];
        wav_en_q <= hwdata[CTRL_WAVE_BIT];
      end else if (wr_addr_q == OFS_OVR_EN) begin
        ovr_en_q <= hwdata[11:0];
      end else if (wr_addr_q == OFS_OVR_VAL) begin
        ovr_val_q <= hwdata[11:0];
      end
    end
  end

  // Read data taken at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_ph && !hwrite) begin
      if (haddr[7:0] == OFS_CTRL) begin
        hrdata <= (32'(wav_en_q) << CTRL_WAVE_BIT) | (32'(run_en_q) << CTRL_RUN_BIT);
      end else if (haddr[7:0] == OFS_STATUS) begin
        hrdata <= (32'(leds) << STAT_LED_LSB) | (32'(mode_q) << STAT_MODE_LSB)
                | (32'(ovrun_q) << STAT_OVRUN_LSB);
      end else if (haddr[7:0] == OFS_OVR_EN) begin
        hrdata <= 32'(ovr_en_q);
      end else if (haddr[7:0] == OFS_OVR_VAL) begin
        hrdata <= 32'(ovr_val_q);
      end else begin
        hrdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Slow phase changes only at the end of a full half period
  AST_SLOW_HALF: assert property ($changed(slow_ph_q) |-> $past(ms_tick)
      && $past(slow_cnt_q) == 12'(SLOW_HALF_MS_P - 1))
    else $error("Slow phase changed early");

  // Fast phase changes only at the end of a fast half period
  AST_FAST_HALF: assert property ($changed(fast_ph_q) |-> $past(ms_tick)
      && $past(fast_cnt_q) == 12'(FAST_HALF_MS_P - 1))
    else $error("Fast phase changed early");

  // A message event arms the flash for the full width
  AST_FLASH_ARM: assert property (chan.msg[2] |=> yel_cnt_q[2] == 12'(FLASH_MS_P))
    else $error("Flash not armed");

  // Waver never darkens the power indicator
  AST_WAVER: assert property (mode_q == LSI_CFG_ERR && ovr_en_q == '0
      |=> leds.pwr_green != leds.pwr_yellow)
    else $error("Waver went dark");

  // Running lights exactly one element
  AST_RUN_ONE: assert property (mode_q == LSI_RUNNING && ovr_en_q == '0 |=> $onehot(12'(leds)))
    else $error("Running not one-hot");

  // Normal mode shows steady green power
  AST_NORMAL_PWR: assert property (mode_q == LSI_NORMAL && ovr_en_q == '0
      |=> leds.pwr_green && !leds.pwr_yellow)
    else $error("Power not steady green");

  // Waiting for configuration: power follows slow phase, traffic dark
  AST_WAIT_CFG: assert property (mode_q == LSI_WAIT_CFG && ovr_en_q == '0
      |=> leds.pwr_yellow == $past(slow_ph_q) && !leds.pwr_green
          && leds.trf_yellow == '0 && leds.trf_red == '0)
    else $error("Wait pattern wrong");

  // Firmware update: all traffic yellow together with fast phase
  AST_UPDATE: assert property (mode_q == LSI_UPDATE && ovr_en_q == '0
      |=> leds.trf_yellow == {NUM_CHAN{$past(fast_ph_q)}} && leds.trf_red == '0)
    else $error("Update pattern wrong");

  // Error passive channel follows the fast phase in red
  AST_PASSIVE: assert property (mode_q == LSI_NORMAL && chan.err_passive[3] && !ovrun_q[3]
      && ovr_en_q == '0 |=> leds.trf_red[3] == $past(fast_ph_q))
    else $error("Passive red wrong");

  // Overrun latches and persists while no bus off arrives
  AST_OVERRUN: assert property (chan.overrun[1] ##1 !chan.bus_off[1] [*2] |=> ovrun_q[1])
    else $error("Overrun latch lost");

  // Full override copies the override value
  AST_OVERRIDE: assert property (ovr_en_q == 12'hFFF |=> 12'(leds) == $past(ovr_val_q))
    else $error("Override ignored");

  // Configuration error beats every lower device condition
  AST_PRIORITY: assert property (dev.fw_cfg_err && !run_en_q |=> mode_q == LSI_CFG_ERR)
    else $error("Priority wrong");

  COV_RUN_WRAP: cover property (mode_q == LSI_RUNNING && run_idx_q == RUN_W'(NUM_ELEM - 1)
      ##1 run_idx_q == '0);
  COV_FLASH: cover property (chan.msg[2] ##1 mode_q == LSI_NORMAL && leds.trf_yellow[2]);
  COV_OVR_CLEAR: cover property (ovrun_q[1] ##1 !ovrun_q[1]);
  COV_WAIT_TO_NORMAL: cover property (mode_q == LSI_WAIT_CFG ##1 mode_q == LSI_NORMAL);

endmodule : lsi_top

// ---- dv/led_status_indicator_tb.sv ----
// Self-checking bench for the indicator controller with the LED observer.
// Assumes shortened timing: 4-cycle ms tick, slow 4, fast 2, flash 3, step 2.
`timescale 1ns/100ps
module led_status_indicator_tb
  import lsi_pkg::*;
;
  localparam int MSC = 4;
  localparam int SLOW_C = 16;
  localparam int FAST_C = 8;
  localparam int FLS = 3;
  localparam int ORD [12] = '{0, 1, 2, 7, 3, 8, 4, 9, 5, 10, 6, 11};

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  lsi_dev_s    dev;
  lsi_chan_s   chan;
  lsi_leds_s   leds;
  logic [11:0] lvec;
  logic [15:0] hi_len [NUM_ELEM];
  logic [15:0] lo_len [NUM_ELEM];
  int          n_mismatch, total_checks;

  assign lvec = leds;

  lsi_top #(.MS_CYCLES_P(MSC), .SLOW_HALF_MS_P(4), .FAST_HALF_MS_P(2), .FLASH_MS_P(FLS),
    .RUN_STEP_MS_P(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev(dev), .chan(chan), .leds(leds));

  lsi_led_watch watch_u (.hclk(hclk), .hresetn(hresetn), .leds(leds), .hi_len(hi_len), .lo_len(lo_len));

  // ----------------------------------------------------------------
  // Reporting and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string w);
    total_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0d want %0d..%0d", $time, w, got, lo, hi);
    end
  endtask : chk_rng

  task automatic hang(input string w);
    n_mismatch++;
    $display("wrong value at %0t: timeout %s", $time, w);
    give_verdict();
  endtask : hang

  // ----------------------------------------------------------------
  // AHB-Lite master, waits and stimulus helpers
  // ----------------------------------------------------------------
  task automatic wait_rdy();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 20) hang("bus");
  endtask : wait_rdy

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    hsize  <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000, "hresp okay");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string w);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp, w);
  endtask : rd_chk

  task automatic wait_led(input int i, input logic v);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge hclk);
      if (lvec[i] === v) break;
    end
    if (k == 200) hang("led");
  endtask : wait_led

  // One-cycle message or error frame pulse on channel c
  task automatic pulse(input int c, input logic err);
    if (err) chan.err_frame[c] <= 1'b1;
    else chan.msg[c] <= 1'b1;
    @(posedge hclk);
    chan.msg       <= '0;
    chan.err_frame <= '0;
  endtask : pulse

  // Watch a device-wide pattern for 32 cycles
  task automatic scan(input logic [11:0] zm, input logic pw, input logic rw);
    repeat (32) begin
      @(posedge hclk);
      chk(32'(lvec & zm), 32'h0000_0000, "dark elements");
      chk(32'(&leds.trf_yellow | ~|leds.trf_yellow), 32'h0000_0001, "yellows together");
      if (pw) chk(32'(leds.pwr_green ^ leds.pwr_yellow), 32'h0000_0001, "power waver");
      if (rw) chk(32'(leds.trf_red ^ leds.trf_yellow), 32'h0000_001F, "traffic waver");
    end
  endtask : scan

  // Clock of 4 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; dev = '0; chan = '0; n_mismatch = 0; total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(OFS_OVR_EN, 32'h0000_0000, "ovr_en reset");
    rd_chk(OFS_OVR_VAL, 32'h0000_0000, "ovr_val reset");
    rd_chk(8'h10, 32'h0000_0000, "unmapped");
    repeat (80) @(posedge hclk);
    chk(32'(lvec & 12'hFFD), 32'h0000_0000, "wait cfg dark");
    chk_rng(hi_len[1], SLOW_C, SLOW_C, "slow on");
    chk_rng(lo_len[1], SLOW_C, SLOW_C, "slow off");
    dev.usb_cfg_done <= 1'b1;
    repeat (40) @(posedge hclk);
    chk(32'(lvec), 32'h0000_0001, "normal idle");
    bus(1'b0, OFS_STATUS, 32'h0000_0000, rv);
    chk(rv & 32'h0000_7000, 32'h0000_1000, "mode normal");
    // Flashes: yellow on ch2, train looks steady, red on ch0
    pulse(2, 1'b0);
    wait_led(4, 1'b1);
    chk(32'(lvec & 12'hFFE), 32'h0000_0010, "yellow flash");
    wait_led(4, 1'b0);
    @(posedge hclk);
    chk_rng(hi_len[4], (FLS - 1) * MSC, (FLS + 1) * MSC + 1, "flash width");
    for (int k = 0; k < 8; k++) begin
      pulse(2, 1'b0);
      repeat (5) @(posedge hclk);
      chk(32'(lvec[4]), 32'h0000_0001, "flash train");
    end
    wait_led(4, 1'b0);
    pulse(0, 1'b1);
    wait_led(7, 1'b1);
    chk(32'(lvec & 12'hFFE), 32'h0000_0080, "red flash");
    // Error passive ch3, then overrun latch on ch1
    chan.err_passive[3] <= 1'b1;
    repeat (60) @(posedge hclk);
    chk_rng(hi_len[10], FAST_C, FAST_C, "passive on");
    chk_rng(lo_len[10], FAST_C, FAST_C, "passive off");
    chan.overrun[1] <= 1'b1;
    @(posedge hclk);
    chan.overrun[1] <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(32'(lvec & 12'h17C), 32'h0000_0100, "overrun latched");
    bus(1'b0, OFS_STATUS, 32'h0000_0000, rv);
    chk(rv & 32'h001F_0000, 32'h0002_0000, "overrun status");
    chan.bus_off[1] <= 1'b1;
    @(posedge hclk);
    chan.bus_off[1] <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'(lvec[8]), 32'h0000_0000, "bus off clears");
    // Device-wide states and their priority over channel traffic
    dev.fw_update <= 1'b1;
    repeat (40) @(posedge hclk);
    scan(12'hF80, 1'b0, 1'b0);
    chk_rng(hi_len[2], FAST_C, FAST_C, "update blink");
    dev.fw_cfg_err <= 1'b1;
    repeat (80) @(posedge hclk);
    scan(12'h000, 1'b1, 1'b1);
    chk_rng(hi_len[0], SLOW_C, SLOW_C, "cfg waver");
    dev.fw_cfg_err <= 1'b0;
    dev.low_power  <= 1'b1;
    repeat (80) @(posedge hclk);
    scan(12'hF80, 1'b1, 1'b0);
    chk_rng(hi_len[2], SLOW_C, SLOW_C, "low power blink");
    // Running sequence from the control register
    wr(OFS_CTRL, 32'h0000_0001);
    rd_chk(OFS_CTRL, 32'h0000_0001, "ctrl rw");
    wait_led(11, 1'b1);
    wait_led(0, 1'b1);
    for (int k = 0; k < 12; k++) begin
      chk(32'(lvec), 32'h0000_0001 << ORD[k], "running step");
      if (k < 11) wait_led(ORD[k + 1], 1'b1);
    end
    chk_rng(hi_len[8], 2 * MSC, 2 * MSC, "step length");
    wr(OFS_CTRL, 32'h0000_0000);
    // Override takes over, wholly and partly, then hands back
    dev <= lsi_dev_s'(4'b1000);
    chan.err_passive <= '0;
    wr(OFS_OVR_VAL, 32'h0000_0A5A);
    wr(OFS_OVR_EN, 32'h0000_0FFF);
    repeat (3) @(posedge hclk);
    chk(32'(lvec), 32'h0000_0A5A, "full override");
    wr(OFS_OVR_EN, 32'h0000_0002);
    repeat (3) @(posedge hclk);
    chk(32'(lvec), 32'h0000_0003, "partial override");
    wr(OFS_OVR_EN, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk(32'(lvec), 32'h0000_0001, "override off");
    // Identify request: every indicator fast-wavers
    wr(OFS_CTRL, 32'h0000_0002);
    rd_chk(OFS_CTRL, 32'h0000_0002, "ctrl wave");
    repeat (20) @(posedge hclk);
    scan(12'h000, 1'b1, 1'b1);
    chk_rng(hi_len[0], FAST_C, FAST_C, "fast waver");
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_OVR_VAL, 32'hFFFF_F000);
    rd_chk(OFS_OVR_VAL, 32'h0000_0000, "upper bits");
    give_verdict();
  end
endmodule : led_status_indicator_tb

// ---- dv/lsi_led_watch.sv ----
// Observer model of the user who watches the twelve colour elements.
// Assumes leds is registered on hclk; it keeps the last on run and the
// last off run of every element, counted in clock cycles.
`timescale 1ns/100ps
module lsi_led_watch
  import lsi_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire lsi_leds_s leds,
  output logic [15:0]    hi_len [NUM_ELEM],
  output logic [15:0]    lo_len [NUM_ELEM]
);
  logic [NUM_ELEM-1:0] prev_q;
  logic [15:0]         run_q [NUM_ELEM];

  // Run length of each of the twelve elements, stored when its level changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= '0;
      for (int i = 0; i < NUM_ELEM; i++) begin
        run_q[i]  <= 16'h0000;
        hi_len[i] <= 16'h0000;
        lo_len[i] <= 16'h0000;
      end
    end else begin
      prev_q <= leds;
      for (int i = 0; i < NUM_ELEM; i++) begin
        if (leds[i] != prev_q[i]) begin
          run_q[i] <= 16'h0001;
          if (prev_q[i]) hi_len[i] <= run_q[i];
          else lo_len[i] <= run_q[i];
        end else begin
          run_q[i] <= run_q[i] + 16'h0001;
        end
      end
    end
  end
endmodule : lsi_led_watch
